// >>> rtl/rcfg_pkg.sv
// rcfg_pkg: register map, field positions, defaults and types of the reset configuration block
package rcfg_pkg;

    // register byte offsets on the slave port
    localparam logic [3:0] RCFG_OFS_RESET_DEFAULT = 4'h0;
    localparam logic [3:0] RCFG_OFS_PART_ID       = 4'h4;
    localparam logic [3:0] RCFG_OFS_SYNTH_STATUS  = 4'h8;
    localparam logic [3:0] RCFG_OFS_CHIP_CONFIG   = 4'hC;

    // field positions of reset_default_config
    localparam int RCFG_CS_LSB       = 8;
    localparam int RCFG_PLL_MODE_BIT = 7;
    localparam int RCFG_PLL_REF_BIT  = 6;
    localparam int RCFG_PAD_BIT      = 5;
    localparam int RCFG_BOOTW_LSB    = 3;
    localparam int RCFG_BOOTDEV_BIT  = 2;
    localparam int RCFG_MODE_BIT     = 0;

    // field positions of synthesizer_status and chip_configuration
    localparam int RCFG_SYN_ENABLE_BIT = 0;
    localparam int RCFG_SYN_REF_BIT    = 1;
    localparam int RCFG_SYN_MODE_BIT   = 2;
    localparam int RCFG_CCR_MODE_LSB   = 8;

    // default configuration reported after reset
    localparam logic [1:0] RCFG_DEF_CS_LAYOUT  = 2'h0;
    localparam logic       RCFG_DEF_PLL_MODE   = 1'h1;
    localparam logic       RCFG_DEF_PLL_REF    = 1'h1;
    localparam logic       RCFG_DEF_PAD_FULL   = 1'h1;
    localparam logic [1:0] RCFG_DEF_BOOT_WIDTH = 2'h0;
    localparam logic       RCFG_DEF_BOOT_DEV   = 1'h0;
    localparam logic       RCFG_DEF_CHIP_MODE  = 1'h0;

    // identity, arbitrary neutral values
    localparam logic [7:0] RCFG_PART_NUMBER = 8'h5A;
    localparam logic [7:0] RCFG_REVISION    = 8'h01;

    // actual chip mode codes and clock mode pin codes
    localparam logic [2:0] RCFG_CHIP_SINGLE = 3'h6;
    localparam logic [2:0] RCFG_CHIP_MASTER = 3'h7;
    localparam logic [1:0] RCFG_CLK_PLL_OFF = 2'h0;
    localparam logic [1:0] RCFG_CLK_ONE_ONE = 2'h1;
    localparam logic [1:0] RCFG_CLK_NORM_EXT = 2'h2;

    // position of each override data pin inside the strap vector
    localparam int RCFG_STRAP_MODE_HI = 7;
    localparam int RCFG_STRAP_CS_HI   = 6;
    localparam int RCFG_STRAP_CS_LO   = 5;
    localparam int RCFG_STRAP_PAD     = 4;
    localparam int RCFG_STRAP_BOOT_HI = 3;
    localparam int RCFG_STRAP_BOOT_LO = 2;
    localparam int RCFG_STRAP_MODE_MI = 1;
    localparam int RCFG_STRAP_MODE_LO = 0;

    // bus answer codes and reset value of waitrequest
    localparam logic [1:0] RCFG_RESP_OKAY       = 2'h0;
    localparam logic [1:0] RCFG_RESP_DECODE_ERR = 2'h3;
    localparam logic       RCFG_RST_WAITREQ     = 1'h1;

    typedef enum logic {
        RCFG_BUS_IDLE   = 1'b0,
        RCFG_BUS_ANSWER = 1'b1
    } rcfg_bus_state_t;

endpackage

// >>> rtl/rcfg_strap_capture.sv
// rcfg_strap_capture: samples override request and override pins while reset is held
`timescale 1ns/1ps
`default_nettype none
module rcfg_strap_capture
    import rcfg_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       config_request_n,
    input  wire logic [7:0] strap_pins,
    input  wire logic [1:0] clock_mode_pins,
    output logic            override_q,
    output logic [7:0]      strap_q,
    output logic [1:0]      clock_mode_q
);

    // follow the pins every edge in reset, freeze at release
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            override_q   <= ~config_request_n;
            strap_q      <= strap_pins;
            clock_mode_q <= clock_mode_pins;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/rcfg_pin_decode.sv
// rcfg_pin_decode: turns captured override pins or defaults into the effective configuration
`timescale 1ns/1ps
`default_nettype none
module rcfg_pin_decode
    import rcfg_pkg::*;
(
    input  wire logic       override,
    input  wire logic [7:0] strap,
    input  wire logic [1:0] clock_mode,
    input  wire logic [1:0] def_cs_layout,
    input  wire logic       def_pll_mode,
    input  wire logic       def_pll_ref,
    input  wire logic       def_pad_full,
    input  wire logic [1:0] def_boot_width,
    input  wire logic       def_boot_dev,
    input  wire logic       def_chip_mode,
    output logic [1:0]      eff_cs_layout,
    output logic            eff_pll_enable,
    output logic            eff_pll_mode,
    output logic            eff_pll_ref,
    output logic            eff_pad_full,
    output logic [1:0]      eff_boot_width,
    output logic            eff_boot_dev,
    output logic [2:0]      eff_chip_mode
);

    wire logic [1:0] pin_cs;
    wire logic [1:0] pin_boot;
    wire logic [2:0] pin_mode;
    wire logic [2:0] def_mode;

    // pin order for one and two selects is swapped against the field encoding
    assign pin_cs   = {strap[RCFG_STRAP_CS_LO], strap[RCFG_STRAP_CS_HI]};
    assign pin_boot = {strap[RCFG_STRAP_BOOT_HI], strap[RCFG_STRAP_BOOT_LO]};
    assign pin_mode = {strap[RCFG_STRAP_MODE_HI], strap[RCFG_STRAP_MODE_MI],
                       strap[RCFG_STRAP_MODE_LO]};
    assign def_mode = def_chip_mode ? RCFG_CHIP_MASTER : RCFG_CHIP_SINGLE;

    // pins win only when the request pin was low in reset
    assign eff_cs_layout  = override ? pin_cs : def_cs_layout;
    assign eff_pll_enable = override ? (clock_mode != RCFG_CLK_PLL_OFF) : 1'b1;
    assign eff_pll_mode   = override ? (clock_mode != RCFG_CLK_ONE_ONE) : def_pll_mode;
    assign eff_pll_ref    = override ? clock_mode[0] : def_pll_ref;
    assign eff_pad_full   = override ? strap[RCFG_STRAP_PAD] : def_pad_full;
    assign eff_boot_width = override ? pin_boot : def_boot_width;
    assign eff_boot_dev   = override ? (pin_boot != 2'h0) : def_boot_dev;
    assign eff_chip_mode  = override ? pin_mode : def_mode;

endmodule
`default_nettype wire

// >>> rtl/rcfg_top.sv
// rcfg_top: reset configuration and part identification registers behind an Avalon-MM slave
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - reset_default_config bits 15:10 and bit 1 always read zero.
// - bits 9:8 report the default chip-select layout, overridable in reset.
// - layout 00 none, 01 select six, 10 six and five, 11 six five four.
// - bit 7 reports default pll mode: 0 one-to-one, 1 normal.
// - actual pll mode after override shows in synthesizer_status mode flag.
// - bit 6 reports default pll reference: 0 external clock, 1 crystal.
// - actual reference after override shows in synthesizer_status reference flag.
// - bit 5 reports default pad strength: 0 partial, 1 full.
// - bits 4:3 report default boot width for external boot, overridable.
// - boot width 00 internal 32, 01 16, 10 8, 11 external 32.
// - bit 2 reports default boot device: 0 internal, 1 external.
// - bit 0 reports default chip mode: 0 single-chip, 1 master.
// - actual chip mode after override shows in chip_configuration mode field.
// - part_identification bits 15:8 give the part number.
// - part_identification bits 7:0 give the mask revision number.
// - reset_default_config is read-only; writes change nothing.
// - override values replace defaults only with request pin low in reset.
module rcfg_top
    import rcfg_pkg::*;
#(
    parameter logic [1:0] DEF_CS_LAYOUT  = RCFG_DEF_CS_LAYOUT,
    parameter logic       DEF_PLL_MODE   = RCFG_DEF_PLL_MODE,
    parameter logic       DEF_PLL_REF    = RCFG_DEF_PLL_REF,
    parameter logic       DEF_PAD_FULL   = RCFG_DEF_PAD_FULL,
    parameter logic [1:0] DEF_BOOT_WIDTH = RCFG_DEF_BOOT_WIDTH,
    parameter logic       DEF_BOOT_DEV   = RCFG_DEF_BOOT_DEV,
    parameter logic       DEF_CHIP_MODE  = RCFG_DEF_CHIP_MODE,
    parameter logic [7:0] PART_NUMBER    = RCFG_PART_NUMBER,
    parameter logic [7:0] REVISION       = RCFG_REVISION
)(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        config_request_n,
    input  wire logic [7:0]  strap_pins,
    input  wire logic [1:0]  clock_mode_pins,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    output logic [1:0]       cfg_cs_layout,
    output logic [2:0]       port_f_chip_select,
    output logic             cfg_pll_enable,
    output logic             cfg_pll_mode,
    output logic             cfg_pll_ref,
    output logic             cfg_pad_full,
    output logic [1:0]       cfg_boot_width,
    output logic             cfg_boot_external,
    output logic [2:0]       cfg_chip_mode
);

    // captured straps and their decoded view
    wire logic       override_q;
    wire logic [7:0] strap_q;
    wire logic [1:0] clock_mode_q;
    wire logic [1:0] eff_cs_layout;
    wire logic       eff_pll_enable;
    wire logic       eff_pll_mode;
    wire logic       eff_pll_ref;
    wire logic       eff_pad_full;
    wire logic [1:0] eff_boot_width;
    wire logic       eff_boot_dev;
    wire logic [2:0] eff_chip_mode;
    wire logic [2:0] def_chip_code;

    // registered configuration, bus state and answer
    logic [1:0]      cs_layout_q;
    logic [2:0]      port_f_cs_q;
    logic [2:0]      port_f_cs_d;
    logic            pll_enable_q;
    logic            pll_mode_q;
    logic            pll_ref_q;
    logic            pad_full_q;
    logic [1:0]      boot_width_q;
    logic            boot_dev_q;
    logic [2:0]      chip_mode_q;
    rcfg_bus_state_t state_q;
    rcfg_bus_state_t state_d;
    logic            waitreq_q;
    logic [31:0]     readdata_q;
    logic [1:0]      response_q;

    // register images and decode
    wire logic [15:0] reset_default_config_value;
    wire logic [15:0] part_id_value;
    wire logic [15:0] synth_value;
    wire logic [15:0] ccr_value;
    wire logic        hit_reset_default_config;
    wire logic        hit_part;
    wire logic        hit_synth;
    wire logic        hit_ccr;
    wire logic        hit_any;
    wire logic        request;
    wire logic        take;
    wire logic [15:0] read_mux;

    rcfg_strap_capture u_capture (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .config_request_n (config_request_n),
        .strap_pins       (strap_pins),
        .clock_mode_pins  (clock_mode_pins),
        .override_q       (override_q),
        .strap_q          (strap_q),
        .clock_mode_q     (clock_mode_q)
    );

    rcfg_pin_decode u_decode (
        .override       (override_q),
        .strap          (strap_q),
        .clock_mode     (clock_mode_q),
        .def_cs_layout  (DEF_CS_LAYOUT),
        .def_pll_mode   (DEF_PLL_MODE),
        .def_pll_ref    (DEF_PLL_REF),
        .def_pad_full   (DEF_PAD_FULL),
        .def_boot_width (DEF_BOOT_WIDTH),
        .def_boot_dev   (DEF_BOOT_DEV),
        .def_chip_mode  (DEF_CHIP_MODE),
        .eff_cs_layout  (eff_cs_layout),
        .eff_pll_enable (eff_pll_enable),
        .eff_pll_mode   (eff_pll_mode),
        .eff_pll_ref    (eff_pll_ref),
        .eff_pad_full   (eff_pad_full),
        .eff_boot_width (eff_boot_width),
        .eff_boot_dev   (eff_boot_dev),
        .eff_chip_mode  (eff_chip_mode)
    );

    assign def_chip_code = DEF_CHIP_MODE ? RCFG_CHIP_MASTER : RCFG_CHIP_SINGLE;

    // port f bit 7-k is a select when the layout counts k+1 or more selects
    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : g_portf
            assign port_f_cs_d[2-k] = (eff_cs_layout > 2'(k));
        end
    endgenerate

    // effective configuration; defaults held throughout reset, port f selects cleared to zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cs_layout_q  <= DEF_CS_LAYOUT;
            port_f_cs_q  <= 3'h0;
            pll_enable_q <= 1'b1;
            pll_mode_q   <= DEF_PLL_MODE;
            pll_ref_q    <= DEF_PLL_REF;
            pad_full_q   <= DEF_PAD_FULL;
            boot_width_q <= DEF_BOOT_WIDTH;
            boot_dev_q   <= DEF_BOOT_DEV;
            chip_mode_q  <= def_chip_code;
        end else begin
            cs_layout_q  <= eff_cs_layout;
            port_f_cs_q  <= port_f_cs_d;
            pll_enable_q <= eff_pll_enable;
            pll_mode_q   <= eff_pll_mode;
            pll_ref_q    <= eff_pll_ref;
            pad_full_q   <= eff_pad_full;
            boot_width_q <= eff_boot_width;
            boot_dev_q   <= eff_boot_dev;
            chip_mode_q  <= eff_chip_mode;
        end
    end

    // defaults are wired constants, so no write path can reach them
    assign reset_default_config_value = {6'h0,
                         DEF_CS_LAYOUT,
                         DEF_PLL_MODE,
                         DEF_PLL_REF,
                         DEF_PAD_FULL,
                         DEF_BOOT_WIDTH,
                         DEF_BOOT_DEV,
                         1'b0,
                         DEF_CHIP_MODE};
    assign part_id_value = {PART_NUMBER, REVISION};
    assign synth_value = {13'h0, pll_mode_q, pll_ref_q, pll_enable_q};
    assign ccr_value   = {5'h0, chip_mode_q, 8'h00};

    // address decode; byte lanes do not matter on a read-only map
    assign hit_reset_default_config  = (avs_address == RCFG_OFS_RESET_DEFAULT);
    assign hit_part  = (avs_address == RCFG_OFS_PART_ID);
    assign hit_synth = (avs_address == RCFG_OFS_SYNTH_STATUS);
    assign hit_ccr   = (avs_address == RCFG_OFS_CHIP_CONFIG);
    assign hit_any   = hit_reset_default_config | hit_part | hit_synth | hit_ccr;
    assign read_mux  = hit_reset_default_config  ? reset_default_config_value :
                       hit_part  ? part_id_value :
                       hit_synth ? synth_value :
                       hit_ccr   ? ccr_value : 16'h0000;
    assign request   = avs_read | avs_write;
    assign take      = request && (state_q == RCFG_BUS_IDLE);

    // one wait cycle per access, then a one-cycle answer
    always_comb begin
        case (state_q)
            RCFG_BUS_IDLE:   state_d = request ? RCFG_BUS_ANSWER : RCFG_BUS_IDLE;
            RCFG_BUS_ANSWER: state_d = RCFG_BUS_IDLE;
            default:         state_d = RCFG_BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q   <= RCFG_BUS_IDLE;
            waitreq_q <= RCFG_RST_WAITREQ;
        end else begin
            state_q   <= state_d;
            waitreq_q <= (state_d != RCFG_BUS_ANSWER);
        end
    end

    // answer latched when taken; writes are answered but store nothing
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            readdata_q <= 32'h0000_0000;
            response_q <= RCFG_RESP_OKAY;
        end else if (take) begin
            readdata_q <= avs_read ? {16'h0000, read_mux} : 32'h0000_0000;
            response_q <= hit_any ? RCFG_RESP_OKAY : RCFG_RESP_DECODE_ERR;
        end
    end

    assign avs_readdata       = readdata_q;
    assign avs_waitrequest    = waitreq_q;
    assign avs_response       = response_q;
    assign cfg_cs_layout      = cs_layout_q;
    assign port_f_chip_select = port_f_cs_q;
    assign cfg_pll_enable     = pll_enable_q;
    assign cfg_pll_mode       = pll_mode_q;
    assign cfg_pll_ref        = pll_ref_q;
    assign cfg_pad_full       = pad_full_q;
    assign cfg_boot_width     = boot_width_q;
    assign cfg_boot_external  = boot_dev_q;
    assign cfg_chip_mode      = chip_mode_q;

    // checks on bus timing, on answered reads and on the configuration outputs
    wire logic rd_ack;
    wire logic wr_ack;
    assign rd_ack = avs_read && !avs_waitrequest;
    assign wr_ack = avs_write && !avs_waitrequest;

    chk_bus_answer: assert property (@(posedge mclk) disable iff (!reset_n)
        take |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("access not answered after one wait cycle");
    chk_reset_default_config_reserved: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_ack && hit_reset_default_config |-> avs_readdata[31:10] == 22'h0 && !avs_readdata[1])
        else $error("reserved default bits not zero");
    chk_reset_default_config_fields: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_ack && hit_reset_default_config |-> avs_readdata[9:8] == DEF_CS_LAYOUT
            && avs_readdata[7] == DEF_PLL_MODE && avs_readdata[6] == DEF_PLL_REF
            && avs_readdata[5] == DEF_PAD_FULL && avs_readdata[4:3] == DEF_BOOT_WIDTH
            && avs_readdata[2] == DEF_BOOT_DEV && avs_readdata[0] == DEF_CHIP_MODE)
        else $error("default field read wrong"); // also
    chk_port_f_map: assert property (@(posedge mclk) disable iff (!reset_n)
        reset_n |=> port_f_cs_q == {$past(eff_cs_layout) != 2'h0, $past(eff_cs_layout) >= 2'h2,
                            $past(eff_cs_layout) == 2'h3})
        else $error("port f select map wrong");
    chk_pll_flags: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_ack && hit_synth |-> avs_readdata[2:0] == {cfg_pll_mode, cfg_pll_ref, cfg_pll_enable})
        else $error("synthesizer flags do not match pll config");
    chk_ccr_mode: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_ack && hit_ccr |-> avs_readdata[10:8] == cfg_chip_mode
            && avs_readdata[15:11] == 5'h0 && avs_readdata[7:0] == 8'h0)
        else $error("chip mode field wrong");
    chk_part_id: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_ack && hit_part |-> avs_readdata == {16'h0000, PART_NUMBER, REVISION})
        else $error("part identification wrong");
    chk_write_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
        wr_ack |=> $stable(cfg_chip_mode) && $stable(cfg_cs_layout) && $stable(cfg_pll_mode))
        else $error("write altered configuration");
    chk_default_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 !override_q |-> cfg_chip_mode == def_chip_code && cfg_cs_layout == DEF_CS_LAYOUT
            && cfg_boot_width == DEF_BOOT_WIDTH && cfg_pll_enable)
        else $error("defaults replaced without request pin");

endmodule
`default_nettype wire

// >>> test/tb_top.sv
// tb_top: register bus and reset override bench for the reset configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rcfg_pkg::*;
;
    logic        mclk             = 1'b0;
    logic        reset_n          = 1'b0;
    logic        config_request_n = 1'b1;
    logic [7:0]  strap_pins       = 8'hFF;
    logic [1:0]  clock_mode_pins  = 2'h0;
    logic [3:0]  avs_address      = 4'h0;
    logic        avs_read         = 1'b0;
    logic        avs_write        = 1'b0;
    logic [31:0] avs_writedata    = 32'h0;
    logic [3:0]  avs_byteenable   = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [1:0]  cfg_cs_layout;
    logic [2:0]  port_f_chip_select;
    logic        cfg_pll_enable;
    logic        cfg_pll_mode;
    logic        cfg_pll_ref;
    logic        cfg_pad_full;
    logic [1:0]  cfg_boot_width;
    logic        cfg_boot_external;
    logic [2:0]  cfg_chip_mode;
    wire  [31:0] cfg_vec;
    int          num_errors = 0;
    int          cmp_count  = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [7:0]  st;
    logic [1:0]  ck;
    logic [1:0]  cs;
    logic [2:0]  md;
    logic [7:0]  st_tab [4] = '{8'hCA, 8'hB7, 8'hEF, 8'h92};
    logic [1:0]  ck_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    localparam logic [31:0] exp_rdc = {16'h0, 6'h00, RCFG_DEF_CS_LAYOUT, RCFG_DEF_PLL_MODE,
        RCFG_DEF_PLL_REF, RCFG_DEF_PAD_FULL, RCFG_DEF_BOOT_WIDTH, RCFG_DEF_BOOT_DEV, 1'b0,
        RCFG_DEF_CHIP_MODE};

    rcfg_top dut (
        .mclk(mclk), .reset_n(reset_n), .config_request_n(config_request_n),
        .strap_pins(strap_pins), .clock_mode_pins(clock_mode_pins),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .cfg_cs_layout(cfg_cs_layout),
        .port_f_chip_select(port_f_chip_select), .cfg_pll_enable(cfg_pll_enable),
        .cfg_pll_mode(cfg_pll_mode), .cfg_pll_ref(cfg_pll_ref), .cfg_pad_full(cfg_pad_full),
        .cfg_boot_width(cfg_boot_width), .cfg_boot_external(cfg_boot_external),
        .cfg_chip_mode(cfg_chip_mode)
    );

    // static configuration outputs packed for one compare
    assign cfg_vec = {19'h0, cfg_cs_layout, port_f_chip_select, cfg_pad_full, cfg_boot_width,
                      cfg_boot_external, cfg_chip_mode, cfg_pll_enable};

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    // pins taken over as selects for each layout code
    function automatic logic [2:0] pf(input logic [1:0] l);
        case (l)
            2'h1:    pf = 3'h4;
            2'h2:    pf = 3'h6;
            2'h3:    pf = 3'h7;
            default: pf = 3'h0;
        endcase
    endfunction

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // masked compare, unknowns in kept bits never match
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g,
                       input logic [31:0] m);
        cmp_count++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e & m, g & m);
        end
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
            summarize();
        end
        rd = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd, m);
        chk("response", 32'h0, {30'h0, rsp}, 32'h3);
    endtask

    // straps are inverted after release so late sampling shows up
    task automatic do_reset(input logic rq, input logic [7:0] s, input logic [1:0] c);
        @(posedge mclk);
        reset_n          <= 1'b0;
        config_request_n <= rq;
        strap_pins       <= s;
        clock_mode_pins  <= c;
        repeat (5) @(posedge mclk);
        reset_n          <= 1'b1;
        config_request_n <= 1'b1;
        strap_pins       <= ~s;
        clock_mode_pins  <= ~c;
        repeat (2) @(posedge mclk);
    endtask

    initial begin
        // defaults with override pins driven but request idle
        do_reset(1'b1, 8'hFF, 2'h0);
        rd_chk("reset_default_config", RCFG_OFS_RESET_DEFAULT, exp_rdc, '1);
        rd_chk("part_identification", RCFG_OFS_PART_ID, {16'h0, RCFG_PART_NUMBER, RCFG_REVISION}, '1);
        rd_chk("synthesizer_status", RCFG_OFS_SYNTH_STATUS, {29'h0, RCFG_DEF_PLL_MODE, RCFG_DEF_PLL_REF, 1'b1}, 32'h7);
        rd_chk("chip_configuration", RCFG_OFS_CHIP_CONFIG, {21'h0, 2'h3, RCFG_DEF_CHIP_MODE, 8'h0}, 32'hFFFF);
        chk("cfg_outputs", {19'h0, RCFG_DEF_CS_LAYOUT, pf(RCFG_DEF_CS_LAYOUT), RCFG_DEF_PAD_FULL, RCFG_DEF_BOOT_WIDTH, RCFG_DEF_BOOT_WIDTH != 2'h0, 2'h3, RCFG_DEF_CHIP_MODE, 1'b1}, cfg_vec, '1);
        chk("cfg_pll", {30'h0, RCFG_DEF_PLL_MODE, RCFG_DEF_PLL_REF},
            {30'h0, cfg_pll_mode, cfg_pll_ref}, 32'h3);
        $display("test defaults done");
        // writes must be dropped; one idle cycle between the two accesses
        bus(1'b1, RCFG_OFS_RESET_DEFAULT, 32'hFFFF_FFFF);
        chk("write_response", 32'h0, {30'h0, rsp}, 32'h3);
        bus(1'b1, RCFG_OFS_PART_ID, 32'h0000_0000);
        chk("write_response", 32'h0, {30'h0, rsp}, 32'h3);
        rd_chk("reset_default_config", RCFG_OFS_RESET_DEFAULT, exp_rdc, '1);
        rd_chk("part_identification", RCFG_OFS_PART_ID, {16'h0, RCFG_PART_NUMBER, RCFG_REVISION}, '1);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped_data", 32'h0, rd, '1);
        chk("unmapped_response", {30'h0, RCFG_RESP_DECODE_ERR}, {30'h0, rsp}, 32'h3);
        $display("test writes done");
        // override request low in reset: every layout, width and clock mode
        for (int i = 0; i < 4; i++) begin
            st = st_tab[i];
            ck = ck_tab[i];
            cs = {st[RCFG_STRAP_CS_LO], st[RCFG_STRAP_CS_HI]};
            md = {st[RCFG_STRAP_MODE_HI], st[RCFG_STRAP_MODE_MI], st[RCFG_STRAP_MODE_LO]};
            do_reset(1'b0, st, ck);
            rd_chk("reset_default_config", RCFG_OFS_RESET_DEFAULT, exp_rdc, '1);
            rd_chk("synthesizer_status", RCFG_OFS_SYNTH_STATUS, {29'h0, ck[1], ck[0], ck != 2'h0}, (ck == 2'h0) ? 32'h1 : (ck[1] ? 32'h7 : 32'h5));
            rd_chk("chip_configuration", RCFG_OFS_CHIP_CONFIG, {21'h0, md, 8'h0}, 32'hFFFF);
            chk("cfg_outputs", {19'h0, cs, pf(cs), st[4], st[3:2], st[3:2] != 2'h0, md, ck != 2'h0}, cfg_vec, '1);
            // with the pll off neither mode nor reference means anything
            if (ck != 2'h0)
                chk("cfg_pll", {30'h0, ck[1], ck[0]},
                    {30'h0, cfg_pll_mode, cfg_pll_ref}, ck[1] ? 32'h3 : 32'h2);
        end
        $display("test overrides done");
        summarize();
    end
endmodule
`default_nettype wire
